// ### spg_pkg.sv
package spg_pkg;
    // Register byte offsets on the system control block
    localparam logic [11:0] SPG_RUN_GATES_OFF   = 12'h108;
    localparam logic [11:0] SPG_SLEEP_GATES_OFF = 12'h118;
    localparam logic [11:0] SPG_DEEP_GATES_OFF  = 12'h128;
    localparam logic [11:0] SPG_RUN_CFG_OFF     = 12'h060;
    localparam logic [11:0] SPG_INT_STAT_OFF    = 12'h1F0;
    localparam logic [11:0] SPG_INT_MASK_OFF    = 12'h1F4;
    localparam logic [11:0] SPG_MODE_STAT_OFF   = 12'h1F8;
    // Field layout
    localparam int          SPG_NUM_PORTS   = 5;
    localparam int          SPG_ACG_BIT     = 11;
    localparam int          SPG_EV_FAULT    = 0;
    localparam int          SPG_EV_MODE     = 1;
    localparam int          SPG_NUM_EV      = 2;
    localparam logic [4:0]  SPG_GATES_RST   = 5'h00;
    localparam logic [31:0] SPG_WORD_ZERO   = 32'h0000_0000;
    // AHB encodings
    localparam logic [1:0]  SPG_HTRANS_NSEQ = 2'h2;
    localparam logic [1:0]  SPG_HTRANS_SEQ  = 2'h3;
    localparam logic [2:0]  SPG_HSIZE_WORD  = 3'h2;
    // Power mode, Gray along run->sleep->deep
    typedef enum logic [1:0] {
        SPG_MODE_RUN   = 2'b00,
        SPG_MODE_SLEEP = 2'b01,
        SPG_MODE_DEEP  = 2'b11
    } spg_mode_t;
endpackage : spg_pkg

// ### spg_gate_if.sv
`timescale 1ns/100ps
// Gate word and its register write strobe shared by the bank
interface spg_gate_if;
    logic       wr_en;   // Write strobe
    logic [4:0] wr_data; // New gate bits
    logic [4:0] gates;   // Stored gate bits
    modport ctl  (output wr_en, output wr_data, input gates);
    modport bank (input wr_en, input wr_data, output gates);
endinterface : spg_gate_if

// ### spg_gate_reg.sv
`timescale 1ns/100ps
// One gating register: five read-write bits, cleared at reset
module spg_gate_reg
    import spg_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Register port
    spg_gate_if.bank  g
);
    logic [4:0] gates_q; // Stored gate bits

    // Gate storage, all ports unclocked after reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gates_q <= SPG_GATES_RST;
        end else if (g.wr_en) begin
            gates_q <= g.wr_data;
        end
    end
    assign g.gates = gates_q;
endmodule : spg_gate_reg

// ### spg_clock_gating.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Sleep gate register sits at 0x118
// - Bits 4..0 gate ports E..A, read-write
// - Bit one clocks port, zero disables it
// - Access to gated-off port gives bus fault
// - Reset clears all gates to zero
// - Bits 31..5 read zero, software preserves
// - Sleep register used only during sleep
// - Sleep gates apply only with auto gating
// - Run gate register at 0x108
// - Deep-sleep gate register at 0x128
module spg_clock_gating
    import spg_pkg::*;
#(
    parameter int NPORTS = SPG_NUM_PORTS
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // AHB-Lite slave
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic      [31:0]       hrdata_out,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    // Power mode requests from the processor
    input  wire logic              sleep_req_in,
    input  wire logic              deep_req_in,
    // Port access monitor from the peripheral bus
    input  wire logic              port_access_in,
    input  wire logic [2:0]        port_sel_in,
    // Port clock enables and fault
    output logic      [NPORTS-1:0] port_clk_en_out,
    output logic                   port_fault_out,
    // Interrupt
    output logic                   irq_out
);
    // Gate registers
    spg_gate_if run_g ();
    spg_gate_if slp_g ();
    spg_gate_if dsp_g ();

    spg_gate_reg u_run (.clk_in(clk_in), .rst_n_in(rst_n_in), .g(run_g));
    spg_gate_reg u_slp (.clk_in(clk_in), .rst_n_in(rst_n_in), .g(slp_g));
    spg_gate_reg u_dsp (.clk_in(clk_in), .rst_n_in(rst_n_in), .g(dsp_g));

    // Address phase capture
    logic        wr_pend_q;   // Write data phase pending
    logic [11:0] wr_addr_q;   // Write offset
    logic        acg_q;       // Auto clock gating select
    logic [1:0]  stat_q;      // Sticky events
    logic [1:0]  mask_q;      // Event mask
    spg_mode_t   mode_q;      // Current power mode
    spg_mode_t   mode_d;      // Next power mode
    logic [4:0]  en_d;        // Next clock enables
    logic        fault_ev;    // Fault seen this cycle
    logic        mode_ev;     // Mode changed this cycle
    logic        addr_ok;     // Address phase valid
    logic [11:0] off;         // Address phase offset
    logic [31:0] rd_d;        // Read mux

    assign addr_ok = hsel_in && hready_in && (htrans_in == SPG_HTRANS_NSEQ || htrans_in == SPG_HTRANS_SEQ);
    assign off     = haddr_in[11:0];

    // Write strobes into the gate banks
    always_comb begin
        run_g.wr_en   = wr_pend_q && (wr_addr_q == SPG_RUN_GATES_OFF);
        slp_g.wr_en   = wr_pend_q && (wr_addr_q == SPG_SLEEP_GATES_OFF);
        dsp_g.wr_en   = wr_pend_q && (wr_addr_q == SPG_DEEP_GATES_OFF);
        run_g.wr_data = hwdata_in[4:0];
        slp_g.wr_data = hwdata_in[4:0];
        dsp_g.wr_data = hwdata_in[4:0];
    end

    // Bus phase tracking; slave answers with no wait state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ok && hwrite_in;
            wr_addr_q <= off;
        end
    end

    // Read mux; upper bits read as zero
    always_comb begin
        rd_d = SPG_WORD_ZERO;
        case (off)
            SPG_RUN_GATES_OFF:   rd_d[4:0] = run_g.gates;
            SPG_SLEEP_GATES_OFF: rd_d[4:0] = slp_g.gates;
            SPG_DEEP_GATES_OFF:  rd_d[4:0] = dsp_g.gates;
            SPG_RUN_CFG_OFF:     rd_d[SPG_ACG_BIT] = acg_q;
            SPG_INT_STAT_OFF:    rd_d[1:0] = stat_q;
            SPG_INT_MASK_OFF:    rd_d[1:0] = mask_q;
            SPG_MODE_STAT_OFF:   rd_d[1:0] = mode_q;
            default:             rd_d = SPG_WORD_ZERO;
        endcase
    end

    // Read data register, loaded in the address phase
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_out    <= SPG_WORD_ZERO;
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1; // Always ready, OKAY response
            hresp_out     <= 1'b0;
            if (addr_ok && !hwrite_in) begin
                hrdata_out <= rd_d;
            end
        end
    end

    // Auto gating select and mask registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acg_q  <= 1'b0;
            mask_q <= 2'b00;
        end else if (wr_pend_q) begin
            if (wr_addr_q == SPG_RUN_CFG_OFF) begin
                acg_q <= hwdata_in[SPG_ACG_BIT];
            end
            if (wr_addr_q == SPG_INT_MASK_OFF) begin
                mask_q <= hwdata_in[1:0];
            end
        end
    end

    // Power mode tracking
    always_comb begin
        if (deep_req_in) begin
            mode_d = SPG_MODE_DEEP;
        end else if (sleep_req_in) begin
            mode_d = SPG_MODE_SLEEP;
        end else begin
            mode_d = SPG_MODE_RUN;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= SPG_MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Select which bank drives the enables; run bank unless auto gating in sleep or deep
    always_comb begin
        case (mode_d)
            SPG_MODE_SLEEP: en_d = acg_q ? slp_g.gates : run_g.gates;
            SPG_MODE_DEEP:  en_d = acg_q ? dsp_g.gates : run_g.gates;
            default:        en_d = run_g.gates;
        endcase
    end

    // Clock enables, registered so ports see a clean edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_clk_en_out <= '0;
        end else begin
            port_clk_en_out <= en_d[NPORTS-1:0];
        end
    end

    // Fault on access to an unclocked port
    assign fault_ev = port_access_in && (port_sel_in < 3'(NPORTS))
                      && !port_clk_en_out[port_sel_in];
    assign mode_ev  = (mode_d != mode_q);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_fault_out <= 1'b0;
        end else begin
            port_fault_out <= fault_ev;
        end
    end

    // Sticky status; a new event wins over a clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_q <= 2'b00;
        end else begin
            for (int i = 0; i < SPG_NUM_EV; i++) begin
                if ((i == SPG_EV_FAULT && fault_ev) || (i == SPG_EV_MODE && mode_ev)) begin
                    stat_q[i] <= 1'b1;
                end else if (wr_pend_q && wr_addr_q == SPG_INT_STAT_OFF && hwdata_in[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_q & mask_q);
        end
    end

    // Assertions
    sequence s_sleep_auto;
        (mode_q == SPG_MODE_SLEEP) && acg_q;
    endsequence

    a_reset_gates_off: assert property (@(posedge clk_in) $rose(rst_n_in) |-> port_clk_en_out == '0)
        else $error("enables not off after reset");
    a_sleep_uses_sleep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_sleep_auto ##1 $stable(mode_q) |-> port_clk_en_out == slp_g.gates[NPORTS-1:0])
        else $error("sleep enables do not follow sleep gates");
    a_run_uses_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (mode_q == SPG_MODE_RUN) ##1 (mode_q == SPG_MODE_RUN) && $stable(run_g.gates)
        |-> port_clk_en_out == run_g.gates[NPORTS-1:0])
        else $error("run enables do not follow run gates");
    a_no_acg_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !acg_q && $stable(acg_q) && $stable(run_g.gates) && $stable(mode_q)
        |=> port_clk_en_out == $past(run_g.gates[NPORTS-1:0]))
        else $error("gating applied without auto select");
    a_deep_uses_deep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (mode_d == SPG_MODE_DEEP) && acg_q |=> port_clk_en_out == $past(dsp_g.gates[NPORTS-1:0]))
        else $error("deep enables do not follow deep gates");
    a_fault_on_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        port_access_in && port_sel_in == 3'h0 && !port_clk_en_out[0] |=> port_fault_out)
        else $error("no fault on gated port access");
    a_no_fault_clocked: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        port_access_in && port_sel_in == 3'h0 && port_clk_en_out[0] |=> !port_fault_out)
        else $error("fault on clocked port");
    a_sleep_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_pend_q && wr_addr_q == SPG_SLEEP_GATES_OFF |=> slp_g.gates == $past(hwdata_in[4:0]))
        else $error("sleep gate write lost");
    a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        addr_ok && !hwrite_in && off == SPG_SLEEP_GATES_OFF |=> hrdata_out[31:5] == '0)
        else $error("reserved bits not zero");
    a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ##1 irq_out == $past(|(stat_q & mask_q)))
        else $error("interrupt level wrong");
endmodule : spg_clock_gating

// ### spg_far_end.sv
`timescale 1ns/100ps
// Far side: peripheral bus master touching one port per request
module spg_far_end (
    // Clock
    input  wire logic       clk_in,
    // Request from bench
    input  wire logic       go_in,
    input  wire logic [2:0] sel_in,
    // Port access monitor
    output logic            port_access_out,
    output logic [2:0]      port_sel_out
);
    // Idle select churns, so a stale port number is never trusted
    initial port_access_out = 1'b0;
    initial port_sel_out    = 3'h5;
    // One cycle of access per request
    always @(posedge clk_in) begin
        port_access_out <= go_in;
        port_sel_out    <= go_in ? sel_in : port_sel_out + 3'h1;
    end
endmodule : spg_far_end

// ### tb_top.sv
`timescale 1ns/100ps
// Bench: AHB driver, scoreboard queue, port access partner
module tb_top
    import spg_pkg::*;
;
    logic        clk, rst_n, hsel, hwrite, sleep_req, deep_req, go, hrdy, hresp, fault, irq, acc, dph_rd;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, sel, psel;
    logic [4:0]  en;
    logic [31:0] expq[$]; // Expected read data
    logic [31:0] slp;     // Random sleep gate word
    int          fails, tests_run, nfault, seed, i;

    spg_clock_gating spg_clock_gating_inst (.clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
        .hresp_out(hresp), .sleep_req_in(sleep_req), .deep_req_in(deep_req),
        .port_access_in(acc), .port_sel_in(psel), .port_clk_en_out(en),
        .port_fault_out(fault), .irq_out(irq));
    spg_far_end spg_far_end_inst (.clk_in(clk), .go_in(go), .sel_in(sel),
        .port_access_out(acc), .port_sel_out(psel));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // Wait for hready under a bound; running out ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            wrap_up();
        end
    endtask : wait_rdy

    // One AHB single word transfer; e is the read expectation
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        htrans <= SPG_HTRANS_NSEQ;
        hwrite <= w;
        hsize  <= SPG_HSIZE_WORD;
        wait_rdy();
        if (!w) expq.push_back(e);
        htrans <= 2'h0;
        hwdata <= w ? d : $random(seed);
        wait_rdy();
    endtask : bus

    // Change power mode, then check the enables follow
    task automatic mode(input logic s, input logic d, input logic [4:0] e);
        sleep_req <= s;
        deep_req  <= d;
        repeat (3) @(posedge clk);
        chk({27'h0, en}, {27'h0, e});
    endtask : mode

    // Monitor: read data against oldest note, fault pulses counted
    always @(posedge clk) begin
        if (dph_rd && hrdy === 1'b1) chk(hrdata, expq.pop_front());
        // Every read data phase must end with an OKAY response
        if (dph_rd && hrdy === 1'b1) chk({31'h0, hresp}, 32'h0000_0000);
        if (fault === 1'b1) nfault++;
        dph_rd <= hsel && htrans == SPG_HTRANS_NSEQ && !hwrite && hrdy === 1'b1;
    end

    initial begin
        {rst_n, hsel, hwrite, sleep_req, deep_req, go, dph_rd} = 7'h00;
        {haddr, hwdata, htrans, hsize, sel} = '0;
        fails = 0;
        tests_run = 0;
        nfault = 0;
        seed = 95247;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({27'h0, en}, 32'h0000_0000);
        bus(1'b0, SPG_SLEEP_GATES_OFF, 0, 0);
        bus(1'b0, SPG_RUN_GATES_OFF, 0, 0);
        bus(1'b0, SPG_DEEP_GATES_OFF, 0, 0);
        slp = $random(seed);
        bus(1'b1, SPG_SLEEP_GATES_OFF, slp, 0);
        bus(1'b0, SPG_SLEEP_GATES_OFF, 0, slp & 32'h0000_001F);
        bus(1'b1, SPG_RUN_GATES_OFF, 32'h0000_0005, 0);
        bus(1'b1, SPG_DEEP_GATES_OFF, 32'h0000_0012, 0);
        bus(1'b0, 12'h200, 0, 0);
        mode(1'b1, 1'b0, 5'h05);
        mode(1'b1, 1'b1, 5'h05);
        mode(1'b1, 1'b0, 5'h05);
        bus(1'b1, SPG_RUN_CFG_OFF, 32'h0000_0800, 0);
        mode(1'b1, 1'b0, slp[4:0]);
        bus(1'b0, SPG_MODE_STAT_OFF, 0, 32'h0000_0001);
        mode(1'b1, 1'b1, 5'h12);
        mode(1'b0, 1'b0, 5'h05);
        // Every port touched; B, D and E are gated off
        bus(1'b1, SPG_INT_MASK_OFF, 32'h0000_0001, 0);
        for (i = 0; i < 5; i++) begin
            sel <= i[2:0];
            go  <= 1'b1;
            @(posedge clk);
            go  <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        chk(nfault, 3);
        chk({31'h0, irq}, 1);
        bus(1'b1, SPG_INT_STAT_OFF, 32'h0000_0003, 0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 0);
        chk(expq.size(), 0);
        wrap_up();
    end
endmodule : tb_top
